// *** verilog/alu_core.sv ***
// Functional notes
// [RL1] Add writes Rd plus source into Rd, sets Z C N V H, one cycle.
// [RL2] Add with carry adds Rd, source and C, sets Z C N V H, one cycle.
// [RL3] Word add puts pair plus constant in pair, sets Z C N V S, two cycles.
// [RL4] Subtract writes Rd minus source into Rd, sets Z C N V H, one cycle.
// [RL5] Constant subtract writes Rd minus K, sets Z C N V H, one cycle.
// [RL6] Subtract with borrow writes Rd minus source minus C, five flags, one cycle.
// [RL7] Constant subtract with borrow writes Rd minus K minus C, one cycle.
// [RL8] Word subtract takes constant from pair, sets Z C N V S, two cycles.
// [RL9] AND with register or constant sets only Z N V, one cycle.
// [RL10] OR with register or constant sets only Z N V, one cycle.
// [RL11] Exclusive OR writes Rd xor source, sets Z N V, one cycle.
// [RL12] Ones complement writes 0xFF minus Rd, sets Z C N V, one cycle.
// [RL13] Set bits ORs mask; clear bits ANDs 0xFF minus mask; Z N V.
// [RL14] Increment and decrement by one set only Z N V, one cycle.
// [RL15] Test ANDs register with itself; clear XORs it; one cycle each.
// [RL16] Unsigned and signed multiply put product in R1:R0, Z C, two cycles.
// [RL17] Mixed multiply takes signed first, unsigned second operand.
// [RL18] Fractional multiplies shift product left one, Z C, two cycles.
// [RL19] Set register loads 0xFF, touches no flag, one cycle.
// [RL20] Relative jump loads PC plus offset plus one, no flags, two cycles.
// [RL21] Unlisted flags and non destination registers keep their values.
// [RL22] Negate writes zero minus Rd, sets Z C N V H, one cycle.
//
// The placing of the registers and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module alu_core (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire alu_pkg::bus_req_t bus_req_in,
  output alu_pkg::bus_rsp_t bus_rsp_out,
  output logic [7:0] flags_out,
  output logic [15:0] pc_out
);
  alu_pkg::core_state_t s_q;
  alu_pkg::core_state_t s_d;
  alu_pkg::cmd_t cmd;
  logic [4:0] dst_idx;
  logic [4:0] pair_lo;
  logic [4:0] pair_hi;
  logic [7:0] op_a;
  logic [7:0] reg_b;
  logic [7:0] imm;
  logic [7:0] arith_a;
  logic [7:0] arith_b;
  logic [7:0] logic_b;
  logic [7:0] logic_res;
  logic [7:0] com_res;
  logic [7:0] nf;
  logic cin;
  logic cmd_go;
  logic carry_flag;
  logic reg_hit;
  logic [8:0] sum9;
  logic [8:0] diff9;
  logic [4:0] hsum5;
  logic [4:0] hdiff5;
  logic add_v;
  logic sub_v;
  logic [15:0] pair_val;
  logic [15:0] kword;
  logic [15:0] jump_off;
  logic [16:0] wsum17;
  logic [16:0] wdiff17;
  logic mul_as;
  logic mul_bs;
  logic mul_fr;
  logic [15:0] mul_prod;
  logic mul_z;
  logic mul_c;
  logic [31:0] rd_word;

  // Sets Z, N and V from a byte result, other flags pass through
  function automatic logic [7:0] with_nzv(input logic [7:0] f, input logic [7:0] r,
                                          input logic v);
    logic [7:0] o;
    o = f;
    o[alu_pkg::FLAG_Z] = (r == 8'h00);
    o[alu_pkg::FLAG_N] = r[7];
    o[alu_pkg::FLAG_V] = v;
    return o;
  endfunction

  // Command decode and operand fetch from the register file
  assign cmd = alu_pkg::cmd_t'(bus_req_in.writedata);
  assign dst_idx = cmd.rd;
  assign pair_lo = {cmd.rd[4:1], 1'b0};
  assign pair_hi = pair_lo | alu_pkg::PAIR_HI_BIT;
  assign op_a = s_q.regs[cmd.rd];
  assign reg_b = s_q.regs[cmd.rr];
  assign imm = cmd.k[7:0];
  assign carry_flag = s_q.flags[alu_pkg::FLAG_C];
  assign pair_val = {s_q.regs[pair_hi], s_q.regs[pair_lo]};
  assign kword = {10'h000, cmd.k[5:0]};
  assign jump_off = {{4{cmd.k[11]}}, cmd.k};
  assign cmd_go = (s_q.state == alu_pkg::ST_IDLE) && bus_req_in.write
                  && !bus_req_in.read && (bus_req_in.address == alu_pkg::ADDR_CMD)
                  && (bus_req_in.byteenable == alu_pkg::BE_FULL);
  assign reg_hit = (bus_req_in.address <= alu_pkg::ADDR_REG_LAST)
                   && (bus_req_in.address[1:0] == 2'b00);

  // Operand, carry-in and multiply mode selection per operation
  always_comb
  begin
    arith_a = op_a;
    arith_b = reg_b;
    logic_b = reg_b;
    cin = 1'b0;
    mul_as = 1'b0;
    mul_bs = 1'b0;
    mul_fr = 1'b0;
    case (cmd.op)
      alu_pkg::ADD_WITH_CARRY, alu_pkg::SUBTRACT_WITH_BORROW:
        cin = carry_flag; // RL2
      alu_pkg::SUBTRACT_CONSTANT, alu_pkg::AND_WITH_CONSTANT,
      alu_pkg::OR_WITH_CONSTANT, alu_pkg::SET_BITS_MASK:
      begin
        arith_b = imm; // RL5
        logic_b = imm; // RL13
      end
      alu_pkg::SUBTRACT_CONST_WITH_BORROW:
      begin
        arith_b = imm; // RL7
        cin = carry_flag;
      end
      alu_pkg::CLEAR_BITS_MASK:
        logic_b = 8'(alu_pkg::ALL_ONES - imm); // RL13
      alu_pkg::INCREMENT_OP, alu_pkg::DECREMENT_OP:
        arith_b = 8'h01; // RL14
      alu_pkg::TWOS_COMPLEMENT_NEGATE:
      begin
        arith_a = 8'h00; // RL22
        arith_b = op_a;
      end
      alu_pkg::ZERO_MINUS_TEST, alu_pkg::CLEAR_REGISTER_OP:
        logic_b = op_a; // RL15
      alu_pkg::SIGNED_MULTIPLY:
      begin
        mul_as = 1'b1;
        mul_bs = 1'b1;
      end
      alu_pkg::MIXED_MULTIPLY:
        mul_as = 1'b1; // RL17
      alu_pkg::FRACTIONAL_UNSIGNED_MULTIPLY:
        mul_fr = 1'b1; // RL18
      alu_pkg::FRACTIONAL_SIGNED_MULTIPLY:
      begin
        mul_as = 1'b1;
        mul_bs = 1'b1;
        mul_fr = 1'b1;
      end
      alu_pkg::FRACTIONAL_MIXED_MULTIPLY:
      begin
        mul_as = 1'b1;
        mul_fr = 1'b1;
      end
      default:
        cin = 1'b0;
    endcase
  end

  // Byte adder and subtractor with nibble carries and overflow
  assign sum9 = {1'b0, arith_a} + {1'b0, arith_b} + {8'h00, cin};
  assign diff9 = {1'b0, arith_a} - {1'b0, arith_b} - {8'h00, cin};
  assign hsum5 = {1'b0, arith_a[3:0]} + {1'b0, arith_b[3:0]} + {4'h0, cin};
  assign hdiff5 = {1'b0, arith_a[3:0]} - {1'b0, arith_b[3:0]} - {4'h0, cin};
  assign add_v = (arith_a[7] & arith_b[7] & ~sum9[7]) | (~arith_a[7] & ~arith_b[7] & sum9[7]);
  assign sub_v = (arith_a[7] & ~arith_b[7] & ~diff9[7]) | (~arith_a[7] & arith_b[7] & diff9[7]);
  assign com_res = 8'(alu_pkg::ALL_ONES - op_a);
  assign wsum17 = {1'b0, pair_val} + {1'b0, kword};
  assign wdiff17 = {1'b0, pair_val} - {1'b0, kword};

  // Logic unit
  always_comb
  begin
    case (cmd.op)
      alu_pkg::OR_REGISTERS, alu_pkg::OR_WITH_CONSTANT, alu_pkg::SET_BITS_MASK:
        logic_res = op_a | logic_b; // RL10
      alu_pkg::EXCLUSIVE_OR, alu_pkg::CLEAR_REGISTER_OP:
        logic_res = op_a ^ logic_b; // RL11
      default:
        logic_res = op_a & logic_b; // RL9
    endcase
  end

  alu_mul_unit u_mul (
    .a_in(op_a),
    .b_in(reg_b),
    .a_signed_in(mul_as),
    .b_signed_in(mul_bs),
    .frac_in(mul_fr),
    .product_out(mul_prod),
    .zero_out(mul_z),
    .carry_out(mul_c)
  );

  // Read data mux, unmapped addresses read as zero
  always_comb
  begin
    rd_word = 32'h00000000;
    if (reg_hit)
      rd_word = {24'h000000, s_q.regs[bus_req_in.address[6:2]]};
    else if (bus_req_in.address == alu_pkg::ADDR_FLAGS)
      rd_word = {24'h000000, s_q.flags};
    else if (bus_req_in.address == alu_pkg::ADDR_PC)
      rd_word = {16'h0000, s_q.pc};
  end

  // Bus slave and execution sequencer
  always_comb
  begin
    s_d = s_q;
    nf = s_q.flags; // RL21
    case (s_q.state)
      alu_pkg::ST_IDLE:
      begin
        if (bus_req_in.read)
        begin
          s_d.rsp.readdata = rd_word;
          s_d.state = alu_pkg::ST_ACK;
        end
        else if (bus_req_in.write)
        begin
          s_d.state = alu_pkg::ST_ACK;
          if (reg_hit && bus_req_in.byteenable[0])
            s_d.regs[bus_req_in.address[6:2]] = bus_req_in.writedata[7:0];
          if (bus_req_in.address == alu_pkg::ADDR_FLAGS && bus_req_in.byteenable[0])
            s_d.flags = bus_req_in.writedata[7:0];
          if (bus_req_in.address == alu_pkg::ADDR_PC)
          begin
            if (bus_req_in.byteenable[0])
              s_d.pc[7:0] = bus_req_in.writedata[7:0];
            if (bus_req_in.byteenable[1])
              s_d.pc[15:8] = bus_req_in.writedata[15:8];
          end
          if (cmd_go)
          begin
            case (cmd.op)
              alu_pkg::ADD_REGISTERS, alu_pkg::ADD_WITH_CARRY, alu_pkg::INCREMENT_OP:
              begin
                s_d.regs[dst_idx] = sum9[7:0]; // RL1
                nf = with_nzv(nf, sum9[7:0], add_v);
                if (cmd.op != alu_pkg::INCREMENT_OP)
                begin
                  nf[alu_pkg::FLAG_C] = sum9[8]; // RL2
                  nf[alu_pkg::FLAG_H] = hsum5[4];
                end
                s_d.flags = nf; // RL14
              end
              alu_pkg::SUBTRACT_REGISTERS, alu_pkg::SUBTRACT_CONSTANT,
              alu_pkg::SUBTRACT_WITH_BORROW, alu_pkg::SUBTRACT_CONST_WITH_BORROW,
              alu_pkg::TWOS_COMPLEMENT_NEGATE, alu_pkg::DECREMENT_OP:
              begin
                s_d.regs[dst_idx] = diff9[7:0]; // RL4
                nf = with_nzv(nf, diff9[7:0], sub_v); // RL6
                if (cmd.op != alu_pkg::DECREMENT_OP)
                begin
                  nf[alu_pkg::FLAG_C] = diff9[8]; // RL22
                  nf[alu_pkg::FLAG_H] = hdiff5[4]; // RL7
                end
                s_d.flags = nf; // RL5
              end
              alu_pkg::AND_REGISTERS, alu_pkg::AND_WITH_CONSTANT, alu_pkg::OR_REGISTERS,
              alu_pkg::OR_WITH_CONSTANT, alu_pkg::EXCLUSIVE_OR, alu_pkg::SET_BITS_MASK,
              alu_pkg::CLEAR_BITS_MASK, alu_pkg::ZERO_MINUS_TEST,
              alu_pkg::CLEAR_REGISTER_OP:
              begin
                s_d.regs[dst_idx] = logic_res; // RL15
                s_d.flags = with_nzv(nf, logic_res, 1'b0); // RL9
              end
              alu_pkg::ONES_COMPLEMENT:
              begin
                s_d.regs[dst_idx] = com_res; // RL12
                nf = with_nzv(nf, com_res, 1'b0);
                nf[alu_pkg::FLAG_C] = 1'b1;
                s_d.flags = nf;
              end
              alu_pkg::SET_REGISTER_ALL_ONES:
                s_d.regs[dst_idx] = alu_pkg::ALL_ONES; // RL19
              alu_pkg::WORD_ADD_IMMEDIATE, alu_pkg::WORD_SUBTRACT_IMMEDIATE:
              begin
                s_d.pend_pc = 1'b0;
                s_d.pend_lo = pair_lo;
                if (cmd.op == alu_pkg::WORD_ADD_IMMEDIATE)
                begin
                  s_d.pend_val = wsum17[15:0]; // RL3
                  nf[alu_pkg::FLAG_C] = wsum17[16];
                  nf[alu_pkg::FLAG_V] = ~pair_val[15] & wsum17[15];
                end
                else
                begin
                  s_d.pend_val = wdiff17[15:0]; // RL8
                  nf[alu_pkg::FLAG_C] = wdiff17[16];
                  nf[alu_pkg::FLAG_V] = pair_val[15] & ~wdiff17[15];
                end
                nf[alu_pkg::FLAG_Z] = (s_d.pend_val == 16'h0000);
                nf[alu_pkg::FLAG_N] = s_d.pend_val[15];
                nf[alu_pkg::FLAG_S] = nf[alu_pkg::FLAG_N] ^ nf[alu_pkg::FLAG_V];
                s_d.pend_flags = nf;
                s_d.state = alu_pkg::ST_EXEC2;
              end
              alu_pkg::UNSIGNED_MULTIPLY, alu_pkg::SIGNED_MULTIPLY,
              alu_pkg::MIXED_MULTIPLY, alu_pkg::FRACTIONAL_UNSIGNED_MULTIPLY,
              alu_pkg::FRACTIONAL_SIGNED_MULTIPLY, alu_pkg::FRACTIONAL_MIXED_MULTIPLY:
              begin
                s_d.pend_pc = 1'b0;
                s_d.pend_lo = alu_pkg::PRODUCT_LO; // RL16
                s_d.pend_val = mul_prod; // RL18
                nf[alu_pkg::FLAG_Z] = mul_z;
                nf[alu_pkg::FLAG_C] = mul_c;
                s_d.pend_flags = nf;
                s_d.state = alu_pkg::ST_EXEC2;
              end
              alu_pkg::RELATIVE_JUMP:
              begin
                s_d.pend_pc = 1'b1;
                s_d.pend_val = 16'(s_q.pc + jump_off + 16'h0001); // RL20
                s_d.pend_flags = s_q.flags;
                s_d.state = alu_pkg::ST_EXEC2;
              end
              default:
                s_d.state = alu_pkg::ST_ACK;
            endcase
          end
        end
      end
      alu_pkg::ST_EXEC2:
      begin
        // Second cycle commits the pair, product or program counter
        if (s_q.pend_pc)
          s_d.pc = s_q.pend_val; // RL20
        else
        begin
          s_d.regs[s_q.pend_lo] = s_q.pend_val[7:0]; // RL16
          s_d.regs[s_q.pend_lo | alu_pkg::PAIR_HI_BIT] = s_q.pend_val[15:8];
        end
        s_d.flags = s_q.pend_flags; // RL3
        s_d.state = alu_pkg::ST_ACK;
      end
      alu_pkg::ST_ACK:
        s_d.state = alu_pkg::ST_IDLE;
      default:
        s_d.state = alu_pkg::ST_IDLE;
    endcase
    s_d.rsp.waitrequest = (s_d.state != alu_pkg::ST_ACK);
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      s_q <= alu_pkg::STATE_RESET;
    else
      s_q <= s_d;
  end

  assign bus_rsp_out = s_q.rsp;
  assign flags_out = s_q.flags;
  assign pc_out = s_q.pc;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_add_sum: assert property ( // RL1
    cmd_go && cmd.op == alu_pkg::ADD_REGISTERS |=>
      s_q.regs[$past(dst_idx)] == 8'($past(op_a) + $past(reg_b)) && !bus_rsp_out.waitrequest)
    else $error("add result or timing wrong");
  a_adc_sum: assert property ( // RL2
    cmd_go && cmd.op == alu_pkg::ADD_WITH_CARRY |=>
      s_q.regs[$past(dst_idx)] == 8'($past(op_a) + $past(reg_b) + {7'h00, $past(carry_flag)}))
    else $error("add with carry result wrong");
  a_word_add_two: assert property ( // RL3
    cmd_go && cmd.op == alu_pkg::WORD_ADD_IMMEDIATE |->
      ##1 bus_rsp_out.waitrequest ##1 !bus_rsp_out.waitrequest
      && {s_q.regs[$past(pair_hi, 2)], s_q.regs[$past(pair_lo, 2)]}
         == 16'($past(pair_val, 2) + $past(kword, 2)))
    else $error("word add result or timing wrong");
  a_sub_borrow: assert property ( // RL4
    cmd_go && cmd.op == alu_pkg::SUBTRACT_REGISTERS |=>
      flags_out[alu_pkg::FLAG_C] == ($past(op_a) < $past(reg_b)))
    else $error("subtract carry wrong");
  a_logic_flags: assert property ( // RL9
    cmd_go && (cmd.op == alu_pkg::AND_WITH_CONSTANT || cmd.op == alu_pkg::OR_REGISTERS) |=>
      !flags_out[alu_pkg::FLAG_V] && (flags_out & 8'h31) == ($past(flags_out) & 8'h31))
    else $error("logic op flags wrong");
  a_com_carry: assert property ( // RL12
    cmd_go && cmd.op == alu_pkg::ONES_COMPLEMENT |=>
      flags_out[alu_pkg::FLAG_C] && s_q.regs[$past(dst_idx)] == ~$past(op_a))
    else $error("ones complement wrong");
  a_inc_keep: assert property ( // RL14
    cmd_go && cmd.op == alu_pkg::INCREMENT_OP |=>
      (flags_out & 8'h31) == ($past(flags_out) & 8'h31) && !bus_rsp_out.waitrequest)
    else $error("increment touched carry or took too long");
  a_mul_pair: assert property ( // RL16
    cmd_go && cmd.op == alu_pkg::UNSIGNED_MULTIPLY |->
      ##2 {s_q.regs[1], s_q.regs[0]} == {8'h00, $past(op_a, 2)} * {8'h00, $past(reg_b, 2)})
    else $error("unsigned product wrong");
  a_frac_shift: assert property ( // RL18
    cmd_go && cmd.op == alu_pkg::FRACTIONAL_UNSIGNED_MULTIPLY |->
      ##2 {s_q.regs[1], s_q.regs[0]}
          == 16'(({8'h00, $past(op_a, 2)} * {8'h00, $past(reg_b, 2)}) << 1))
    else $error("fractional product wrong");
  a_ser_flags: assert property ( // RL19
    cmd_go && cmd.op == alu_pkg::SET_REGISTER_ALL_ONES |=>
      $stable(flags_out) && s_q.regs[$past(dst_idx)] == 8'hFF)
    else $error("set register wrong");
  a_jump_target: assert property ( // RL20
    cmd_go && cmd.op == alu_pkg::RELATIVE_JUMP |->
      ##2 pc_out == 16'($past(pc_out, 2) + $past(jump_off, 2) + 16'h0001) && $stable(flags_out))
    else $error("relative jump target wrong");
  a_neg_value: assert property ( // RL22
    cmd_go && cmd.op == alu_pkg::TWOS_COMPLEMENT_NEGATE |=>
      s_q.regs[$past(dst_idx)] == 8'(8'h00 - $past(op_a)))
    else $error("negate result wrong");
endmodule // alu_core
`default_nettype wire

// *** verilog/alu_pkg.sv ***
`default_nettype none
package alu_pkg;
  // Register map, byte addresses
  localparam int unsigned REG_COUNT = 32;
  localparam logic [7:0] ADDR_REG_LAST = 8'h7C;
  localparam logic [7:0] ADDR_FLAGS = 8'h80;
  localparam logic [7:0] ADDR_PC = 8'h84;
  localparam logic [7:0] ADDR_CMD = 8'h88;
  localparam logic [3:0] BE_FULL = 4'hF;
  // Status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  // Constants and reset values
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [4:0] PRODUCT_LO = 5'h00;
  localparam logic [4:0] PAIR_HI_BIT = 5'h01;

  typedef enum logic [4:0] {
    ADD_REGISTERS = 5'h00,
    ADD_WITH_CARRY = 5'h01,
    WORD_ADD_IMMEDIATE = 5'h02,
    SUBTRACT_REGISTERS = 5'h03,
    SUBTRACT_CONSTANT = 5'h04,
    SUBTRACT_WITH_BORROW = 5'h05,
    SUBTRACT_CONST_WITH_BORROW = 5'h06,
    WORD_SUBTRACT_IMMEDIATE = 5'h07,
    AND_REGISTERS = 5'h08,
    AND_WITH_CONSTANT = 5'h09,
    OR_REGISTERS = 5'h0A,
    OR_WITH_CONSTANT = 5'h0B,
    EXCLUSIVE_OR = 5'h0C,
    ONES_COMPLEMENT = 5'h0D,
    TWOS_COMPLEMENT_NEGATE = 5'h0E,
    SET_BITS_MASK = 5'h0F,
    CLEAR_BITS_MASK = 5'h10,
    INCREMENT_OP = 5'h11,
    DECREMENT_OP = 5'h12,
    ZERO_MINUS_TEST = 5'h13,
    CLEAR_REGISTER_OP = 5'h14,
    SET_REGISTER_ALL_ONES = 5'h15,
    UNSIGNED_MULTIPLY = 5'h16,
    SIGNED_MULTIPLY = 5'h17,
    MIXED_MULTIPLY = 5'h18,
    FRACTIONAL_UNSIGNED_MULTIPLY = 5'h19,
    FRACTIONAL_SIGNED_MULTIPLY = 5'h1A,
    FRACTIONAL_MIXED_MULTIPLY = 5'h1B,
    RELATIVE_JUMP = 5'h1C
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC2 = 2'b01,
    ST_ACK = 2'b10
  } state_t;

  // Command word layout
  typedef struct packed {
    logic [3:0] spare_hi;
    logic [11:0] k;
    logic spare_lo;
    logic [4:0] rr;
    logic [4:0] rd;
    op_t op;
  } cmd_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } bus_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } bus_rsp_t;

  typedef struct packed {
    state_t state;
    bus_rsp_t rsp;
    logic [REG_COUNT-1:0][7:0] regs;
    logic [7:0] flags;
    logic [15:0] pc;
    logic [15:0] pend_val;
    logic [4:0] pend_lo;
    logic [7:0] pend_flags;
    logic pend_pc;
  } core_state_t;

  localparam core_state_t STATE_RESET = '{
    state: ST_IDLE,
    rsp: '{waitrequest: 1'b1, readdata: 32'h00000000},
    regs: '0,
    flags: FLAGS_RESET,
    pc: PC_RESET,
    pend_val: 16'h0000,
    pend_lo: 5'h00,
    pend_flags: 8'h00,
    pend_pc: 1'b0
  };
endpackage
`default_nettype wire

// *** verilog/alu_mul_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module alu_mul_unit (
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic a_signed_in,
  input wire logic b_signed_in,
  input wire logic frac_in,
  output logic [15:0] product_out,
  output logic zero_out,
  output logic carry_out
);
  logic signed [8:0] a_ext;
  logic signed [8:0] b_ext;
  logic signed [17:0] full;
  logic [15:0] raw;

  // Sign or zero extend each operand, then one signed multiply
  assign a_ext = {a_signed_in & a_in[7], a_in};
  assign b_ext = {b_signed_in & b_in[7], b_in};
  assign full = a_ext * b_ext;
  assign raw = full[15:0];
  // Carry is bit 15 before the fractional shift
  assign carry_out = raw[15];
  assign product_out = frac_in ? {raw[14:0], 1'b0} : raw;
  assign zero_out = (product_out == 16'h0000);
endmodule // alu_mul_unit
`default_nettype wire

// *** bench/bus_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire alu_pkg::bus_req_t req_in,
  input wire alu_pkg::bus_rsp_t rsp_in,
  output alu_pkg::bus_req_t req_out,
  output logic done_out,
  output logic [31:0] rdata_out,
  output logic [3:0] lat_out
);
  // Holds each request until waitrequest is sampled low, then shows the inverse on released lines
  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      req_out <= '0;
      done_out <= 1'b0;
      rdata_out <= 32'h00000000;
      lat_out <= 4'h0;
    end
    else if (go_in)
    begin
      req_out <= req_in;
      done_out <= 1'b0;
      lat_out <= 4'h0;
    end
    else if ((req_out.read || req_out.write) && !rsp_in.waitrequest)
    begin
      req_out <= '{read: 1'b0, write: 1'b0, address: ~req_out.address,
                   writedata: ~req_out.writedata, byteenable: ~req_out.byteenable};
      rdata_out <= rsp_in.readdata;
      done_out <= 1'b1;
      lat_out <= lat_out + 4'h1;
    end
    else
    begin
      done_out <= 1'b0;
      if (req_out.read || req_out.write)
        lat_out <= lat_out + 4'h1;
    end
  end
endmodule // bus_master_model
`default_nettype wire

// *** bench/eight_bit_alu_multiplier_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module eight_bit_alu_multiplier_test;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic go = 1'b0;
  logic done;
  logic [3:0] lat;
  logic [31:0] rdata, q;
  logic [7:0] flags_out;
  logic [15:0] pc_out;
  logic [15:0] seed = 16'hE649;
  alu_pkg::bus_req_t preq = '0;
  alu_pkg::bus_req_t req;
  alu_pkg::bus_rsp_t rsp;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  alu_core u_alu_core (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .bus_req_in(req),
    .bus_rsp_out(rsp), .flags_out(flags_out), .pc_out(pc_out));
  bus_master_model u_bus_master_model (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .go_in(go),
    .req_in(preq),
    .rsp_in(rsp), .req_out(req), .done_out(done), .rdata_out(rdata), .lat_out(lat));
  // Next value of the stimulus shift register
  function logic [15:0] nxt();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  // Expected flags and result of a byte operation
  function automatic logic [15:0] ref8(input logic [4:0] o, input logic [7:0] a, bi, k, f);
    logic [8:0] r;
    logic [4:0] l;
    logic [7:0] b;
    logic s, c, v;
    b = o inside {5'h04, 5'h06, 5'h09, 5'h0B, 5'h0F} ? k : o == 5'h10 ? ~k : bi;
    s = o inside {[5'h03:5'h06], 5'h0E};
    c = o inside {5'h01, 5'h05, 5'h06} && f[0];
    if (o inside {5'h13, 5'h14}) b = a;
    if (o == 5'h0E)
    begin
      b = a;
      a = 8'h00;
    end
    l = s ? a[3:0] - b[3:0] - c : a[3:0] + b[3:0] + c;
    case (o)
      5'h00, 5'h01: r = a + b + c;
      5'h03, 5'h04, 5'h05, 5'h06, 5'h0E: r = a - b - c;
      5'h08, 5'h09, 5'h10, 5'h13: r = {1'b0, a & b};
      5'h0A, 5'h0B, 5'h0F: r = {1'b0, a | b};
      5'h0C, 5'h14: r = {1'b0, a ^ b};
      5'h0D: r = {1'b1, ~a};
      5'h11: r = a + 8'h01;
      5'h12: r = a - 8'h01;
      default: r = 9'h0FF;
    endcase
    v = s ? a[7] != b[7] && r[7] != a[7] : o < 5'h02 ? a[7] == b[7] && r[7] != a[7]
      : o == 5'h11 ? r[7:0] == 8'h80 : o == 5'h12 && r[7:0] == 8'h7F;
    if (o < 5'h07 || o inside {5'h0D, 5'h0E}) f[0] = r[8];
    if (o < 5'h07 || o == 5'h0E) f[5] = l[4];
    if (o != 5'h15) f[3:1] = {v, r[7], r[7:0] == 8'h00};
    return {f, r[7:0]};
  endfunction
  // Expected product with its carry on top
  function automatic logic [16:0] refmul(input logic [4:0] o, input logic [7:0] a, b);
    logic signed [16:0] sa, sb;
    logic [15:0] p;
    sa = o inside {5'h17, 5'h18, 5'h1A, 5'h1B} ? {{9{a[7]}}, a} : {9'h000, a};
    sb = o inside {5'h17, 5'h1A} ? {{9{b[7]}}, b} : {9'h000, b};
    p = 16'(sa * sb);
    return {p[15], o > 5'h18 ? p << 1 : p};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One bus transfer through the partner, waiting for its completion
  task automatic xfer(input logic r, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    go <= 1'b1;
    preq <= '{r, !r, a, d, 4'hF};
    @(posedge sys_clk_in);
    go <= 1'b0;
    #1;
    while (done !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    if (done !== 1'b1)
      n_errors++;
    q = rdata;
  endtask
  task automatic cmd(input logic [4:0] o, d, s, input logic [11:0] k, input logic [3:0] l);
    xfer(1'b0, 8'h88, {4'h0, k, 1'b0, s, d, o});
    chk(lat, l);
  endtask
  task automatic rreg(input logic [4:0] i);
    xfer(1'b1, {1'b0, i, 2'b00}, 32'h0);
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cuts a hang short
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    logic [7:0] a, b, k, f;
    logic [4:0] o, d, s;
    logic [15:0] e, w;
    logic [16:0] p;
    repeat (6) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(posedge sys_clk_in);
    xfer(1'b1, 8'h8C, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 66; i++)
    begin
      o = 5'(i % 22);
      d = 5'(nxt());
      s = d + 5'h01 + 5'(nxt() % 30);
      a = i < 22 ? 8'hFF : 8'(nxt());
      b = i < 22 ? 8'h01 : 8'(nxt());
      k = 8'(nxt());
      f = 8'(nxt());
      xfer(1'b0, {1'b0, d, 2'b00}, {24'h0, a});
      xfer(1'b0, {1'b0, s, 2'b00}, {24'h0, b});
      xfer(1'b0, 8'h80, {24'h0, f});
      e = ref8(o, a, b, k, f);
      if (o == 5'h02 || o == 5'h07) e = {f, a};
      cmd(o, d, s, {4'h0, k}, o == 5'h02 || o == 5'h07 ? 4'h3 : 4'h2);
      if (o == 5'h02 || o == 5'h07) continue;
      chk(flags_out, e[15:8]);
      rreg(d);
      chk(q, e[7:0]);
      rreg(s);
      chk(q, b);
    end
    $display("test byte ops done");
    for (int i = 0; i < 18; i++)
    begin
      o = 5'(22 + i % 6);
      d = 5'(2 + nxt() % 30);
      s = 5'(2 + (d - 1 + nxt() % 29) % 30);
      a = i < 6 ? 8'h80 : 8'(nxt());
      b = i < 6 ? 8'h80 : 8'(nxt());
      f = 8'(nxt());
      xfer(1'b0, {1'b0, d, 2'b00}, {24'h0, a});
      xfer(1'b0, {1'b0, s, 2'b00}, {24'h0, b});
      xfer(1'b0, 8'h80, {24'h0, f});
      p = refmul(o, a, b);
      cmd(o, d, s, 12'h000, 4'h3);
      chk(flags_out, {f[7:2], p[15:0] == 16'h0, p[16]});
      rreg(5'h00);
      chk(q, p[7:0]);
      rreg(5'h01);
      chk(q, p[15:8]);
    end
    $display("test multiply done");
    for (int i = 0; i < 8; i++)
    begin
      o = i[0] ? 5'h07 : 5'h02;
      d = 5'(nxt());
      w = i < 2 ? {16{!i[0]}} : nxt();
      k = i < 2 ? 8'h01 : 8'(nxt() % 64);
      f = 8'(nxt());
      xfer(1'b0, {1'b0, d[4:1], 3'b000}, {24'h0, w[7:0]});
      xfer(1'b0, {1'b0, d[4:1], 3'b100}, {24'h0, w[15:8]});
      xfer(1'b0, 8'h80, {24'h0, f});
      p = i[0] ? w - k : w + k;
      a = {f[7:5], 1'b0, i[0] ? w[15] & !p[15] : !w[15] & p[15], p[15], p[15:0] == 16'h0, p[16]};
      a[4] = a[3] ^ a[2];
      cmd(o, d, 5'h00, {4'h0, k}, 4'h3);
      chk(flags_out, a);
      rreg({d[4:1], 1'b0});
      chk(q, p[7:0]);
      rreg({d[4:1], 1'b1});
      chk(q, p[15:8]);
    end
    $display("test word ops done");
    for (int i = 0; i < 5; i++)
    begin
      w = nxt();
      k = 8'(nxt());
      e = i == 0 ? 16'h0800 : {4'h0, 12'(nxt())};
      xfer(1'b0, 8'h84, {16'h0, w});
      xfer(1'b0, 8'h80, {24'h0, k});
      cmd(i == 4 ? 5'h1D : 5'h1C, 5'h00, 5'h00, e[11:0], 4'h3 - (i == 4));
      chk(pc_out, i == 4 ? w : 16'(w + {{4{e[11]}}, e[11:0]} + 16'h1));
      chk(flags_out, k);
    end
    $display("test jump done");
    final_report();
  end
endmodule // eight_bit_alu_multiplier_test
`default_nettype wire
